/* common/dgc_pkg.sv */
// package: dual gain pixel combiner constants and carriers
package dgc_pkg;
  localparam int ADC_W      = 11;
  localparam int OUT_W      = 16;
  localparam int NARROW_W   = 12;
  localparam int GAIN_W     = 16;
  localparam int GAIN_FRAC  = 12;
  localparam int FIFO_DEPTH = 16;
  localparam logic [ADC_W-1:0]  THRESH_RST = 11'h7c0;
  localparam logic [OUT_W-1:0]  OUT_MAX    = 16'hffff;
  localparam logic [NARROW_W-1:0] NARROW_MAX = 12'hfff;

  // gain setting, one per frame
  typedef enum logic [1:0] {
    DGC_HIGH_CAP  = 2'b00,
    DGC_LOW_NOISE = 2'b01,
    DGC_COMBINED  = 2'b10
  } dgc_mode_type;

  // one stream sample with its compensation data
  typedef struct packed {
    logic [ADC_W-1:0]  sample;
    logic [ADC_W-1:0]  offset;
    logic [GAIN_W-1:0] gain;
  } dgc_chan_type;

  // both gain samples of one pixel
  typedef struct packed {
    dgc_chan_type hi;
    dgc_chan_type lo;
  } dgc_pix_type;

  // merged output word
  typedef struct packed {
    logic             half;
    logic             last;
    logic [OUT_W-1:0] value;
  } dgc_out_type;
endpackage : dgc_pkg

/* hw/dgc_combiner.sv */
// file: dual gain pixel combiner, top and bottom halves merged into one stream
`timescale 1ns/100ps
module dgc_combiner (
  input  wire logic                        clock,
  input  wire logic                        srst,
  input  wire dgc_pkg::dgc_mode_type       mode,
  input  wire logic [dgc_pkg::ADC_W-1:0]   threshold,
  input  wire logic                        frame_start,
  input  wire logic [1:0]                  pix_valid,
  output logic      [1:0]                  pix_ready,
  input  wire logic [1:0]                  pix_last,
  input  wire dgc_pkg::dgc_pix_type        pix_top,
  input  wire dgc_pkg::dgc_pix_type        pix_bot,
  output logic                             out_valid,
  input  wire logic                        out_ready,
  output dgc_pkg::dgc_out_type             out_data,
  output logic                             frame_done
);
  localparam int PROD_W = dgc_pkg::ADC_W + dgc_pkg::GAIN_W;
  localparam int FW     = $bits(dgc_pkg::dgc_out_type);

  //----------------------------------------
  // frame settings
  //----------------------------------------
  dgc_pkg::dgc_mode_type          mode_r, mode_nxt;
  logic [dgc_pkg::ADC_W-1:0]      thr_r, thr_nxt;

  always_comb begin
    mode_nxt = frame_start ? mode : mode_r;
    thr_nxt  = frame_start ? threshold : thr_r;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mode_r <= dgc_pkg::DGC_COMBINED;
      thr_r  <= dgc_pkg::THRESH_RST;
    end else begin
      mode_r <= mode_nxt;
      thr_r  <= thr_nxt;
    end
  end

  //----------------------------------------
  // per half select and compensate
  //----------------------------------------
  dgc_pkg::dgc_pix_type pix   [2];
  dgc_pkg::dgc_out_type res_r [2];
  dgc_pkg::dgc_out_type res_nxt [2];
  logic [1:0]           rv_r, rv_nxt, take, drain;

  assign pix[0] = pix_top;
  assign pix[1] = pix_bot;

  genvar h;
  generate
    for (h = 0; h < 2; h++) begin : g_half
      dgc_pkg::dgc_chan_type ch;
      logic [dgc_pkg::ADC_W-1:0] diff;
      logic [PROD_W-1:0]         prod;
      logic [PROD_W-dgc_pkg::GAIN_FRAC-1:0] scaled;
      always_comb begin
        unique case (mode_r)
          dgc_pkg::DGC_HIGH_CAP:  ch = pix[h].lo;
          dgc_pkg::DGC_LOW_NOISE: ch = pix[h].hi;
          default:
            ch = (pix[h].hi.sample >= thr_r) ? pix[h].lo : pix[h].hi;
        endcase
        diff   = (ch.sample > ch.offset) ? ch.sample - ch.offset : '0;
        prod   = PROD_W'(diff) * PROD_W'(ch.gain);
        scaled = prod[PROD_W-1:dgc_pkg::GAIN_FRAC];
        res_nxt[h] = res_r[h];
        if (take[h]) begin
          res_nxt[h].half = 1'(h);
          res_nxt[h].last = pix_last[h];
          if (mode_r == dgc_pkg::DGC_COMBINED) begin
            res_nxt[h].value = (scaled > PROD_W'(dgc_pkg::OUT_MAX)) ?
                               dgc_pkg::OUT_MAX : 16'(scaled);
          end else begin
            res_nxt[h].value = (scaled > PROD_W'(dgc_pkg::NARROW_MAX)) ?
                               16'(dgc_pkg::NARROW_MAX) : 16'(scaled[dgc_pkg::NARROW_W-1:0]);
          end
        end
      end
      always_comb begin
        take[h]   = pix_valid[h] && pix_ready[h];
        rv_nxt[h] = take[h] | (rv_r[h] & ~drain[h]);
      end
      always_ff @(posedge clock) begin
        if (srst) begin
          res_r[h] <= '0;
          rv_r[h]  <= 1'b0;
        end else begin
          res_r[h] <= res_nxt[h];
          rv_r[h]  <= rv_nxt[h];
        end
      end
      assign pix_ready[h] = !rv_r[h] || drain[h];
    end
  endgenerate

  //----------------------------------------
  // merge halves into the fifo
  //----------------------------------------
  logic                  pick_r, pick_nxt, f_ready, f_valid;
  logic                  ov_r, ov_nxt, fd_r, fd_nxt;
  logic [1:0]            last_seen_r, last_seen_nxt;
  dgc_pkg::dgc_out_type  od_r, od_nxt, f_data;
  logic                  sel;
  logic [FW-1:0]         f_out;

  always_comb begin
    // alternate halves so both streams progress
    sel = (rv_r[0] && rv_r[1]) ? pick_r : rv_r[1];
    drain = '0;
    if (f_ready && (rv_r != 2'b00)) begin
      drain[sel] = 1'b1;
    end
    pick_nxt = (drain != 2'b00) ? ~sel : pick_r;
    // a last word draining with frame_start still counts
    last_seen_nxt = frame_start ? 2'b00 : last_seen_r;
    fd_nxt = 1'b0;
    if (drain != 2'b00 && res_r[sel].last) begin
      last_seen_nxt[sel] = 1'b1;
    end
    if (last_seen_nxt == 2'b11) begin
      fd_nxt = 1'b1;
      last_seen_nxt = 2'b00;
    end
    f_data = res_r[sel];
    f_data.last = fd_nxt;
    ov_nxt = ov_r;
    od_nxt = od_r;
    if (!ov_r || out_ready) begin
      ov_nxt = f_valid;
      od_nxt = dgc_pkg::dgc_out_type'(f_out);
    end
  end

  dgc_fifo #(
    .WIDTH (FW),
    .DEPTH (dgc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .srst      (srst),
    .in_valid  (drain != 2'b00),
    .in_ready  (f_ready),
    .in_data   (f_data),
    .out_valid (f_valid),
    .out_ready (!ov_r || out_ready),
    .out_data  (f_out)
  );

  always_ff @(posedge clock) begin
    if (srst) begin
      pick_r      <= 1'b0;
      last_seen_r <= 2'b00;
      fd_r        <= 1'b0;
      ov_r        <= 1'b0;
      od_r        <= '0;
    end else begin
      pick_r      <= pick_nxt;
      last_seen_r <= last_seen_nxt;
      fd_r        <= fd_nxt;
      ov_r        <= ov_nxt;
      od_r        <= od_nxt;
    end
  end

  assign out_valid  = ov_r;
  assign out_data   = od_r;
  assign frame_done = fd_r;
endmodule : dgc_combiner

//----------------------------------------
// parameterised synchronous fifo
//----------------------------------------
module dgc_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r, wp_nxt, rp_r, rp_nxt;
  logic             push, pop;

  always_comb begin
    push   = in_valid && in_ready;
    pop    = out_valid && out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end

  assign in_ready  = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign out_valid = (wp_r != rp_r);
  assign out_data  = mem[rp_r[AW-1:0]];
endmodule : dgc_fifo

/* hw/dgc_fifo.sv */
// fifo buffer: its module is defined beside the combiner logic

/* tb/dgc_combiner_monitor.sv */
// checker for the combiner ports
`timescale 1ns/100ps
module dgc_combiner_monitor (
  input wire logic                  clock,
  input wire logic                  srst,
  input wire dgc_pkg::dgc_mode_type mode,
  input wire logic                  frame_start,
  input wire logic [1:0]            pix_valid,
  input wire logic [1:0]            pix_ready,
  input wire logic                  out_valid,
  input wire logic                  out_ready,
  input wire dgc_pkg::dgc_out_type  out_data,
  input wire logic                  frame_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  dgc_pkg::dgc_mode_type m_r, m_nxt;
  always_comb m_nxt = frame_start ? mode : m_r;
  always_ff @(posedge clock) m_r <= srst ? dgc_pkg::DGC_COMBINED : m_nxt;

  property p_rst;
    disable iff (1'b0) srst |=> !out_valid && !frame_done && pix_ready == 2'b11
      && out_data == '0;
  endproperty
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
  property p_narrow;
    out_valid && m_r != dgc_pkg::DGC_COMBINED |-> out_data.value <= 16'h0fff;
  endproperty
  property p_lat_t; pix_valid[0] && pix_ready[0] |-> ##[1:60] out_valid; endproperty
  property p_lat_b; pix_valid[1] && pix_ready[1] |-> ##[1:60] out_valid; endproperty
  property p_pulse; frame_done |=> !frame_done; endproperty
  property p_done; frame_done |-> ##[0:30] (out_valid && out_data.last); endproperty
  property p_idle; (!out_valid && pix_valid == 2'b00) [*4] |=> !out_valid; endproperty
  a_rst:    assert property (p_rst)    else $error("bad reset state");
  a_hold:   assert property (p_hold)   else $error("output moved while held");
  a_narrow: assert property (p_narrow) else $error("narrow word too wide");
  a_lat_t:  assert property (p_lat_t)  else $error("top pixel lost");
  a_lat_b:  assert property (p_lat_b)  else $error("bottom pixel lost");
  a_pulse:  assert property (p_pulse)  else $error("frame_done too long");
  a_done:   assert property (p_done)   else $error("no frame end word");
  a_idle:   assert property (p_idle)   else $error("word from nowhere");
  c_both:  cover property (pix_valid == 2'b11 && pix_ready == 2'b11);
  c_stall: cover property (out_valid && !out_ready ##1 out_valid);
  c_last:  cover property (out_valid && out_data.last);
  c_full:  cover property (pix_valid[0] && !pix_ready[0]);
endmodule : dgc_combiner_monitor

bind dgc_combiner dgc_combiner_monitor u_mon (.clock, .srst, .mode, .frame_start,
  .pix_valid, .pix_ready, .out_valid, .out_ready, .out_data, .frame_done);

/* tb/dgc_host_sink.sv */
// host side sink model for merged words
`timescale 1ns/100ps
module dgc_host_sink (
  input  wire logic                 clock,
  input  wire logic                 stall,
  input  wire logic                 out_valid,
  output logic                      out_ready,
  input  wire dgc_pkg::dgc_out_type out_data
);
  dgc_pkg::dgc_out_type got[$];
  initial out_ready = 1'b0;
  // words are taken only on a valid and ready edge
  always @(posedge clock) begin
    if (out_valid && out_ready) got.push_back(out_data);
    out_ready <= !stall;
  end
endmodule : dgc_host_sink

/* tb/tb_dgc_combiner.sv */
// testbench for the dual gain pixel combiner
`timescale 1ns/100ps
module tb_dgc_combiner;
  logic clock = 0, srst = 1, frame_start = 0, stall = 0;
  dgc_pkg::dgc_mode_type mode = dgc_pkg::DGC_COMBINED;
  logic [10:0] threshold = 11'h7c0;
  logic [1:0] pix_valid = 2'h0, pix_last = 2'h0, pix_ready;
  dgc_pkg::dgc_pix_type pix_top = '0, pix_bot = '0;
  logic out_valid, out_ready, frame_done;
  dgc_pkg::dgc_out_type out_data;
  int n_errors = 0, total_checks = 0, cyc = 0, nd = 0;

  dgc_combiner u_dut (.clock, .srst, .mode, .threshold, .frame_start, .pix_valid,
    .pix_ready, .pix_last, .pix_top, .pix_bot, .out_valid, .out_ready, .out_data,
    .frame_done);
  dgc_host_sink u_host (.clock, .stall, .out_valid, .out_ready, .out_data);

  always #25 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (frame_done === 1'b1) nd++;
    if (cyc == 6000) begin
      n_errors++;
      conclude();
    end
  end

  task check(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // hi gain 1.0, lo gain 4.0 in 4.12
  function dgc_pkg::dgc_pix_type px(input logic [10:0] h, l);
    px = {h, 11'h00a, 16'h1000, l, 11'h005, 16'h4000};
  endfunction : px
  function int ev(input int s, o, g, mx);
    int v;
    v = s > o ? ((s - o) * g) >>> 12 : 0;
    return v > mx ? mx : v;
  endfunction : ev
  task automatic send(input int h, input dgc_pkg::dgc_pix_type p);
    if (h) pix_bot <= p;
    else pix_top <= p;
    pix_valid[h] <= 1'b1;
    pix_last[h] <= 1'b1;
    @(negedge clock);
    while (pix_ready[h] !== 1'b1) @(negedge clock);
    @(posedge clock);
    pix_valid[h] <= 1'b0;
    pix_last[h] <= 1'b0;
  endtask : send
  task automatic frame(input dgc_pkg::dgc_mode_type m, input logic [10:0] th,
                       input dgc_pkg::dgc_pix_type t, b, input int et, eb);
    @(posedge clock);
    mode <= m;
    threshold <= th;
    frame_start <= 1'b1;
    @(posedge clock);
    frame_start <= 1'b0;
    u_host.got.delete();
    nd = 0;
    fork send(0, t); send(1, b); join
    for (int i = 0; i < 50 && u_host.got.size() < 2; i++) @(posedge clock);
    check(u_host.got.size(), 2);
    for (int k = 0; k < u_host.got.size(); k++) begin
      check(u_host.got[k].value, u_host.got[k].half ? eb : et);
      check(u_host.got[k].last, k == 1);
    end
    check(nd, 1);
  endtask : frame
  task t_comb;
    frame(dgc_pkg::DGC_COMBINED, 11'h7c0, px(100, 900), px(11'h7c0, 300),
          ev(100, 10, 4096, 65535), ev(300, 5, 16384, 65535));
    $display("t_comb end");
  endtask : t_comb
  task t_thr;
    frame(dgc_pkg::DGC_COMBINED, 11'h032, px(60, 70), px(49, 70),
          ev(70, 5, 16384, 65535), ev(49, 10, 4096, 65535));
    $display("t_thr end");
  endtask : t_thr
  task t_narrow;
    frame(dgc_pkg::DGC_HIGH_CAP, 11'h7c0, px(3, 2047), px(900, 4),
          ev(2047, 5, 16384, 4095), 0);
    frame(dgc_pkg::DGC_LOW_NOISE, 11'h7c0, px(2000, 9), px(5, 9),
          ev(2000, 10, 4096, 4095), 0);
    $display("t_narrow end");
  endtask : t_narrow
  task t_full;
    int n;
    n = 0;
    @(posedge clock);
    stall <= 1'b1;
    mode <= dgc_pkg::DGC_COMBINED;
    frame_start <= 1'b1;
    @(posedge clock);
    frame_start <= 1'b0;
    pix_top <= px(100, 1);
    pix_valid[0] <= 1'b1;
    u_host.got.delete();
    repeat (40) begin
      @(negedge clock);
      if (pix_ready[0] === 1'b1) n++;
    end
    check(pix_ready[0], 0);
    check(n, dgc_pkg::FIFO_DEPTH + 2);
    @(posedge clock);
    pix_valid[0] <= 1'b0;
    stall <= 1'b0;
    for (int k = 0; k < 200 && u_host.got.size() < n; k++) @(posedge clock);
    check(u_host.got.size(), n);
    check(u_host.got[n-1].value, ev(100, 10, 4096, 65535));
    $display("t_full end");
  endtask : t_full
  task conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    t_comb();
    t_thr();
    t_narrow();
    t_full();
    conclude();
  end
endmodule : tb_dgc_combiner
